// [common/amc_pkg.sv]
// Constants, register map and types for the converter mode configuration register bank.
package amc_pkg;

   // ==========================================================================
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_STATUS    = 8'h01;
   localparam logic [7:0] IDX_RATE_FILT = 8'h02;
   localparam logic [7:0] IDX_CONV_CTRL = 8'h03;
   localparam logic [7:0] IDX_AUX_SETUP = 8'h04;
   localparam logic [7:0] IDX_AUX_DATA  = 8'h05;
   localparam logic [7:0] IDX_SAMPLE    = 8'h20;

   // ==========================================================================
   // Values after reset and writable bit masks.
   localparam logic [7:0] RST_RATE_FILT  = 8'h24;
   localparam logic [7:0] RST_CONV_CTRL  = 8'h01;
   localparam logic [7:0] RST_AUX_SETUP  = 8'h00;
   localparam logic [7:0] RST_AUX_DATA   = 8'h00;
   localparam logic [7:0] MASK_CONV_CTRL = 8'h3F;
   localparam logic [7:0] MASK_AUX_DATA  = 8'h4F;

   // ==========================================================================
   // Field positions.
   localparam int RATE_LSB    = 3;
   localparam int CHOP_BIT    = 5;
   localparam int SHOT_BIT    = 4;
   localparam int CONNECT_LSB = 4;
   localparam int PREFIX_BIT  = 6;
   localparam int NEWFLAG_BIT = 2;

   // ==========================================================================
   // Filter codes.
   localparam logic [2:0] FILT_FIR     = 3'h4;
   localparam logic [2:0] FILT_RES_MIN = 3'h5;

   // ==========================================================================
   // Output rates in tenths of a sample per second, indexed by rate code.
   localparam logic [4:0] RATE_CODE_MAX = 5'h10;
   localparam int unsigned RATE_TENTHS [0:16] = '{25, 50, 100, 166, 200, 500, 600, 1000,
      4000, 12000, 24000, 48000, 72000, 144000, 192000, 256000, 400000};

   // ==========================================================================
   // Start delays in nanoseconds, indexed by delay code, and the clock period.
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam logic [3:0]  DLY_CODE_MAX  = 4'hC;
   localparam logic [3:0]  DLY_CODE_DEF  = 4'h1;
   localparam int unsigned DLY_NS [0:12] = '{0, 50000, 59000, 67000, 85000, 119000,
      189000, 328000, 605000, 1160000, 2270000, 4490000, 8930000};

   // ==========================================================================
   // Conversion start sequencing states.
   typedef enum logic [1:0] {AMC_IDLE, AMC_WAIT, AMC_RUN} amc_conv_state_t;

endpackage

// [verilog/amc_mode_regs.sv]
// Mode configuration register bank with APB slave, start delay and auxiliary pins.
//
// The implementer's own choice: the APB register port.

// Functional notes
// - Rate code sits in rate register bits 7:3; 00000 is 2.5 SPS, reset 00100.
// - Codes 00101..01000 give 50, 60, 100, 400 SPS; higher codes run faster.
// - Bits 2:0 pick sinc1..sinc4 or FIR (100, reset); 101..111 reserved.
// - Conversion control bit 5 selects normal (0, reset) or auto-zero (1).
// - Conversion control bit 4 selects continuous (0, reset) or one-shot (1).
// - Bits 3:0 choose start delay; 0001 is 50 us, 1100 is 8.93 ms.
// - Codes 0010..1011 give 59 us up to 4.49 ms; 0000 gives no delay.
// - Aux pin setup bits 7:4 connect each pin function; default disconnected.
// - Function 0 uses shared positive ref pin, function 1 shared negative ref pin.
// - Setup bits 3:0 make a pin output (0, reset) or input (1).
// - Data bits 3:0 read or write the pin levels, resetting low.
// - Data register bit 6 prefixes the status byte to sample reads.
// - Status byte bit 2 flags a sample not yet read.
module amc_mode_regs
   import amc_pkg::*;
#(
   parameter int unsigned DELAY_SHRINK = 1
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [9:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        sample_valid_i,
   input  wire logic [23:0] sample_data_i,
   input  wire logic        conv_start_i,
   input  wire logic        conv_stop_i,
   input  wire logic        pos_ref1_shared_pin_i,
   output logic             pos_ref1_shared_pin_o,
   output logic             pos_ref1_shared_pin_oe_o,
   input  wire logic        neg_ref1_shared_pin_i,
   output logic             neg_ref1_shared_pin_o,
   output logic             neg_ref1_shared_pin_oe_o,
   input  wire logic [1:0]  aux_pin_i,
   output logic      [1:0]  aux_pin_o,
   output logic      [1:0]  aux_pin_oe_o,
   output logic      [4:0]  output_rate_code_o,
   output logic      [18:0] rate_tenth_sps_o,
   output logic      [2:0]  filter_sel_o,
   output logic             offset_chop_select_o,
   output logic             single_shot_select_o,
   output logic      [17:0] start_delay_cycles_o,
   output logic             conv_run_o,
   output logic             status_prefix_enable_o,
   output logic             new_sample_flag_o
);

   // ==========================================================================
   // Declarations.
   logic [7:0]  rate_filter_config, next_rate_filter_config;
   logic [7:0]  conversion_control_config, next_conversion_control_config;
   logic [7:0]  aux_pin_setup, next_aux_pin_setup;
   logic [7:0]  aux_pin_data_and_readout_config, next_aux_pin_data_and_readout_config;
   logic        new_sample_flag, next_new_sample_flag;
   logic [23:0] sample_word, next_sample_word;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic [3:0]  pin_meta;
   logic [3:0]  pin_sync;
   logic [3:0]  pin_out, next_pin_out;
   logic [3:0]  pin_oe, next_pin_oe;
   logic [18:0] next_rate_tenth;
   logic [2:0]  next_filter_sel;
   logic [17:0] next_delay_cycles;
   amc_conv_state_t conv_state, next_conv_state;
   logic [17:0] delay_cnt, next_delay_cnt;
   logic [7:0]  acc_idx;
   logic        acc_hit;
   logic        setup_phase;
   logic        wr_done;
   logic        rd_sample_done;
   logic [7:0]  status_byte;
   logic [3:0]  level_read;

   // ==========================================================================
   // Bus decode; one word per register, misaligned addresses are unmapped.
   assign acc_idx        = paddr_i[9:2];
   assign acc_hit        = (paddr_i[1:0] == 2'h0) &&
                           (acc_idx == IDX_STATUS || acc_idx == IDX_RATE_FILT ||
                            acc_idx == IDX_CONV_CTRL || acc_idx == IDX_AUX_SETUP ||
                            acc_idx == IDX_AUX_DATA || acc_idx == IDX_SAMPLE);
   assign setup_phase    = psel_i && !penable_i;
   assign wr_done        = psel_i && penable_i && pready_o && pwrite_i && acc_hit;
   assign rd_sample_done = psel_i && penable_i && pready_o && !pwrite_i &&
                           acc_hit && (acc_idx == IDX_SAMPLE);
   assign status_byte    = {5'h00, new_sample_flag, 2'h0};

   // An input pin that is connected reads its sampled level, otherwise the stored bit.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         level_read[i] = (aux_pin_setup[CONNECT_LSB + i] && aux_pin_setup[i]) ?
                         pin_sync[i] : aux_pin_data_and_readout_config[i];
      end
   end

   // ==========================================================================
   // Register file next state; a new sample beats a clearing read in the same cycle.
   always_comb begin
      next_rate_filter_config             = rate_filter_config;
      next_conversion_control_config      = conversion_control_config;
      next_aux_pin_setup                  = aux_pin_setup;
      next_aux_pin_data_and_readout_config = aux_pin_data_and_readout_config;
      next_sample_word                    = sample_word;
      next_new_sample_flag                = new_sample_flag;
      if (wr_done) begin
         unique case (acc_idx)
            IDX_RATE_FILT: next_rate_filter_config = pwdata_i[7:0];
            // Reserved bits are forced to zero so they always read back clean.
            IDX_CONV_CTRL: next_conversion_control_config = pwdata_i[7:0] & MASK_CONV_CTRL;
            IDX_AUX_SETUP: next_aux_pin_setup = pwdata_i[7:0];
            IDX_AUX_DATA:  next_aux_pin_data_and_readout_config =
                              pwdata_i[7:0] & MASK_AUX_DATA;
            default:       next_rate_filter_config = rate_filter_config;
         endcase
      end
      if (rd_sample_done) begin
         next_new_sample_flag = 1'b0;
      end
      if (sample_valid_i) begin
         next_sample_word     = sample_data_i;
         next_new_sample_flag = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rate_filter_config              <= RST_RATE_FILT;
         conversion_control_config       <= RST_CONV_CTRL;
         aux_pin_setup                   <= RST_AUX_SETUP;
         aux_pin_data_and_readout_config <= RST_AUX_DATA;
         sample_word                     <= 24'h000000;
         new_sample_flag                 <= 1'b0;
      end else begin
         rate_filter_config              <= next_rate_filter_config;
         conversion_control_config       <= next_conversion_control_config;
         aux_pin_setup                   <= next_aux_pin_setup;
         aux_pin_data_and_readout_config <= next_aux_pin_data_and_readout_config;
         sample_word                     <= next_sample_word;
         new_sample_flag                 <= next_new_sample_flag;
      end
   end

   // ==========================================================================
   // APB answer; read data is captured in the setup cycle so every access has no wait.
   always_comb begin
      next_pready  = setup_phase;
      next_pslverr = setup_phase && !acc_hit;
      next_prdata  = prdata_o;
      if (setup_phase && !pwrite_i) begin
         next_prdata = 32'h00000000;
         if (acc_hit) begin
            unique case (acc_idx)
               IDX_STATUS:    next_prdata = {24'h000000, status_byte};
               IDX_RATE_FILT: next_prdata = {24'h000000, rate_filter_config};
               IDX_CONV_CTRL: next_prdata = {24'h000000, conversion_control_config};
               IDX_AUX_SETUP: next_prdata = {24'h000000, aux_pin_setup};
               IDX_AUX_DATA:  next_prdata = {24'h000000,
                                 aux_pin_data_and_readout_config[7:4], level_read};
               IDX_SAMPLE:    next_prdata = aux_pin_data_and_readout_config[PREFIX_BIT] ?
                                 {status_byte, sample_word} :
                                 {8'h00, sample_word};
               default:       next_prdata = 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prdata_o  <= 32'h00000000;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         prdata_o  <= next_prdata;
         pready_o  <= next_pready;
         pslverr_o <= next_pslverr;
      end
   end

   // ==========================================================================
   // Pin drive; a pin is driven only when connected and set as output.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         next_pin_oe[i]  = next_aux_pin_setup[CONNECT_LSB + i] && !next_aux_pin_setup[i];
         next_pin_out[i] = next_pin_oe[i] && next_aux_pin_data_and_readout_config[i];
      end
   end

   // The meta stage feeds only the sync stage, since pins are asynchronous.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_meta <= 4'h0;
         pin_sync <= 4'h0;
         pin_out  <= 4'h0;
         pin_oe   <= 4'h0;
      end else begin
         pin_meta <= {aux_pin_i, neg_ref1_shared_pin_i, pos_ref1_shared_pin_i};
         pin_sync <= pin_meta;
         pin_out  <= next_pin_out;
         pin_oe   <= next_pin_oe;
      end
   end

   // Functions 0 and 1 share the reference input pins, 2 and 3 have their own.
   assign pos_ref1_shared_pin_o    = pin_out[0];
   assign pos_ref1_shared_pin_oe_o = pin_oe[0];
   assign neg_ref1_shared_pin_o    = pin_out[1];
   assign neg_ref1_shared_pin_oe_o = pin_oe[1];
   assign aux_pin_o                = pin_out[3:2];
   assign aux_pin_oe_o             = pin_oe[3:2];

   // ==========================================================================
   // Mode decode, taken from next values so decoded outputs align with the register.
   always_comb begin
      int unsigned dly;
      logic [4:0]  rc;
      logic [3:0]  dc;
      dly = 0;
      rc  = next_rate_filter_config[7:RATE_LSB];
      dc  = next_conversion_control_config[3:0];
      // Codes past the top of the table clamp to the fastest rate.
      if (rc > RATE_CODE_MAX) begin
         rc = RATE_CODE_MAX;
      end
      next_rate_tenth = 19'(RATE_TENTHS[rc]);
      // Reserved filter codes fall back to the FIR so the filter is never undefined.
      next_filter_sel = (next_rate_filter_config[2:0] >= FILT_RES_MIN) ?
                        FILT_FIR : next_rate_filter_config[2:0];
      // Reserved delay codes fall back to the default delay.
      if (dc > DLY_CODE_MAX) begin
         dc = DLY_CODE_DEF;
      end
      dly = DLY_NS[dc] / CLK_PERIOD_NS / DELAY_SHRINK;
      if (dc != 4'h0 && dly == 0) begin
         dly = 1;
      end
      next_delay_cycles = 18'(dly);
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rate_tenth_sps_o     <= 19'(RATE_TENTHS[4]);
         filter_sel_o         <= FILT_FIR;
         start_delay_cycles_o <= 18'(DLY_NS[1] / CLK_PERIOD_NS / DELAY_SHRINK);
      end else begin
         rate_tenth_sps_o     <= next_rate_tenth;
         filter_sel_o         <= next_filter_sel;
         start_delay_cycles_o <= next_delay_cycles;
      end
   end

   assign output_rate_code_o     = rate_filter_config[7:RATE_LSB];
   assign offset_chop_select_o   = conversion_control_config[CHOP_BIT];
   assign single_shot_select_o   = conversion_control_config[SHOT_BIT];
   assign status_prefix_enable_o = aux_pin_data_and_readout_config[PREFIX_BIT];
   assign new_sample_flag_o      = new_sample_flag;

   // ==========================================================================
   // Start sequencing; the delay is counted before run rises, one-shot ends on a sample.
   always_comb begin
      next_conv_state = conv_state;
      next_delay_cnt  = delay_cnt;
      unique case (conv_state)
         AMC_IDLE: begin
            if (conv_start_i) begin
               next_delay_cnt  = start_delay_cycles_o;
               next_conv_state = (start_delay_cycles_o == 18'h00000) ? AMC_RUN : AMC_WAIT;
            end
         end
         AMC_WAIT: begin
            next_delay_cnt = delay_cnt - 18'h00001;
            if (conv_stop_i) begin
               next_conv_state = AMC_IDLE;
            end else if (delay_cnt <= 18'h00001) begin
               next_conv_state = AMC_RUN;
            end
         end
         AMC_RUN: begin
            if (conv_stop_i || (single_shot_select_o && sample_valid_i)) begin
               next_conv_state = AMC_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         conv_state <= AMC_IDLE;
         delay_cnt  <= 18'h00000;
         conv_run_o <= 1'b0;
      end else begin
         conv_state <= next_conv_state;
         delay_cnt  <= next_delay_cnt;
         conv_run_o <= (next_conv_state == AMC_RUN);
      end
   end

   // ==========================================================================
   // Checks.
   sequence wr_rate_s;
      wr_done && acc_idx == IDX_RATE_FILT;
   endsequence
   sequence shot_done_s;
      conv_run_o && single_shot_select_o && sample_valid_i;
   endsequence

   rate_code_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_rate_s |=> output_rate_code_o == $past(pwdata_i[7:3]))
      else $error("Rate code did not follow the write.");
   rate_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      output_rate_code_o == 5'h08 |-> rate_tenth_sps_o == 19'h00FA0)
      else $error("Rate code 8 is not 400 samples per second.");
   filter_reserved_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rate_filter_config[2:0] >= 3'h5 |-> filter_sel_o == 3'h4)
      else $error("Reserved filter code did not select the FIR.");
   chop_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (wr_done && acc_idx == IDX_CONV_CTRL) |=>
         offset_chop_select_o == $past(pwdata_i[5]) && conversion_control_config[7:6] == 2'h0)
      else $error("Auto-zero select did not follow the write.");
   shot_end_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      shot_done_s and !conv_stop_i |=> !conv_run_o)
      else $error("One-shot run did not end after its sample.");
   delay_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      conversion_control_config[3:0] == 4'h2 |->
         start_delay_cycles_o == 18'(59000 / 50 / DELAY_SHRINK))
      else $error("Delay code 2 is not 59 microseconds.");
   zero_delay_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (conv_state == AMC_IDLE && conv_start_i && start_delay_cycles_o == 18'h00000) |=>
         conv_run_o)
      else $error("Zero delay start did not run at once.");
   shared_pin_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (wr_done && acc_idx == IDX_AUX_SETUP) |=>
         pos_ref1_shared_pin_oe_o == ($past(pwdata_i[4]) && !$past(pwdata_i[0])))
      else $error("Shared positive pin enable is wrong after setup write.");
   input_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (setup_phase && !pwrite_i && paddr_i == {IDX_AUX_DATA, 2'h0} &&
       aux_pin_setup[7] && aux_pin_setup[3]) |=>
         prdata_o[3] == $past(pin_sync[3]) && !aux_pin_oe_o[1])
      else $error("Input pin read did not return the sampled level.");
   prefix_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (setup_phase && !pwrite_i && paddr_i == {IDX_SAMPLE, 2'h0}) |=>
         prdata_o[31:24] == ($past(status_prefix_enable_o) ? $past(status_byte) : 8'h00))
      else $error("Status prefix on sample read is wrong.");
   flag_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      sample_valid_i |=> new_sample_flag_o ##0 status_byte[2])
      else $error("New sample did not raise the flag.");
   flag_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (rd_sample_done && !sample_valid_i) |=> !new_sample_flag_o)
      else $error("Sample read did not clear the flag.");

endmodule // amc_mode_regs

// [tb/amc_pin_model.sv]
// Outside-world model of the four auxiliary pins and their foreign drivers.
module amc_pin_model (
   input  wire logic [3:0] oe_i,
   input  wire logic [3:0] dout_i,
   input  wire logic [3:0] ext_i,
   output logic      [3:0] level_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // A pin the device leaves undriven follows the outside driver, never its own stale value.
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         level_o[k] = oe_i[k] ? dout_i[k] : ext_i[k];
      end
   end
endmodule // amc_pin_model

// [tb/tb.sv]
// Self-checking bench for the converter mode register bank.
module tb;
   import amc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic        sample_valid_i = 0, conv_start_i = 0, pready_o, pslverr_o, conv_run_o;
   logic        chop_o, shot_o, prefix_o, flag_o, conv_stop_i = 0;
   logic [9:0]  paddr_i = '0;
   logic [31:0] pwdata_i = '0, prdata_o, q;
   logic [23:0] sample_data_i = '0;
   logic [3:0]  ext = 4'hA, lvl;
   // Bits 0, 1 and 3:2 have separate port drivers, so these are nets rather than variables.
   wire  [3:0]  oe, dout;
   logic [4:0]  rate_o;
   logic [18:0] tenth_o;
   logic [2:0]  filt_o;
   logic [17:0] dly_o;
   logic        err;
   int          failures = 0, comparisons = 0, k;
   // ==========================================================================
   // Device and pin environment.
   amc_mode_regs #(.DELAY_SHRINK(1)) amc_mode_regs_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .sample_valid_i(sample_valid_i), .sample_data_i(sample_data_i),
      .conv_start_i(conv_start_i), .conv_stop_i(conv_stop_i),
      .pos_ref1_shared_pin_i(lvl[0]), .pos_ref1_shared_pin_o(dout[0]),
      .pos_ref1_shared_pin_oe_o(oe[0]), .neg_ref1_shared_pin_i(lvl[1]),
      .neg_ref1_shared_pin_o(dout[1]), .neg_ref1_shared_pin_oe_o(oe[1]),
      .aux_pin_i(lvl[3:2]), .aux_pin_o(dout[3:2]), .aux_pin_oe_o(oe[3:2]),
      .output_rate_code_o(rate_o), .rate_tenth_sps_o(tenth_o), .filter_sel_o(filt_o),
      .offset_chop_select_o(chop_o), .single_shot_select_o(shot_o),
      .start_delay_cycles_o(dly_o), .conv_run_o(conv_run_o),
      .status_prefix_enable_o(prefix_o), .new_sample_flag_o(flag_o));
   amc_pin_model amc_pin_model_i (.oe_i(oe), .dout_i(dout), .ext_i(ext), .level_o(lvl));
   // 20 MHz clock.
   always #25 clk_i = ~clk_i;
   // ==========================================================================
   // Compare, bus and stimulus tasks.
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // The request is held until pready is seen high at a rising edge, giving up after 20 further edges.
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      // Answer and read data are taken at the very edge that completes the access.
      q = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n == 20) begin
         failures++;
      end
      // Registers update on that edge, so callers compare only once it has settled.
      @(negedge clk_i);
   endtask
   // One-cycle start or stop pulse, returning once the answering edge has settled.
   task automatic ctl(input logic st, input logic sp);
      @(posedge clk_i);
      conv_start_i <= st;
      conv_stop_i <= sp;
      @(posedge clk_i);
      conv_start_i <= 1'b0;
      conv_stop_i <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic rdc(input string n, input logic [9:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, q, e);
   endtask
   task automatic smp(input logic [23:0] d);
      @(posedge clk_i);
      sample_valid_i <= 1'b1;
      sample_data_i <= d;
      @(posedge clk_i);
      sample_valid_i <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic stop_test;
      if (failures == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Watchdog; the whole sequence needs well under 10000 cycles.
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      stop_test;
   end
   // ==========================================================================
   // Test sequence.
   initial begin
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(negedge clk_i);
      chk("reset decode", {rate_o, filt_o, tenth_o}, {5'h04, 3'h4, 19'h000C8});
      chk("reset delay", dly_o, 32'h000003E8);
      rdc("rate reset", 10'h008, 32'h24);
      rdc("ctrl reset", 10'h00C, 32'h01);
      rdc("setup reset", 10'h010, 32'h00);
      rdc("data reset", 10'h014, 32'h00);
      for (k = 0; k <= 16; k++) begin
         apb(1'b1, 10'h008, k << 3);
         chk("rate code", rate_o, k);
         chk("rate value", tenth_o, RATE_TENTHS[k]);
      end
      for (k = 0; k < 8; k++) begin
         apb(1'b1, 10'h008, 8'h20 | k);
         chk("filter", filt_o, (k > 4) ? 4 : k);
         rdc("rate readback", 10'h008, 8'h20 | k);
      end
      apb(1'b1, 10'h00C, 8'h30);
      chk("chop and shot", {chop_o, shot_o}, 2'b11);
      // Rate stays slow while the zero delay code is tried.
      for (k = 0; k < 16; k++) begin
         apb(1'b1, 10'h00C, 8'h10 | k);
         chk("delay", dly_o, DLY_NS[(k > 12) ? 1 : k] / CLK_PERIOD_NS);
      end
      apb(1'b1, 10'h00C, 8'h11);
      ctl(1'b1, 1'b0);
      k = 0;
      while (conv_run_o !== 1'b1 && k < 5000) begin
         @(negedge clk_i);
         k++;
      end
      chk("start delay", k, DLY_NS[1] / CLK_PERIOD_NS);
      smp(24'hABCDEF);
      chk("one shot end", {conv_run_o, flag_o}, 2'b01);
      rdc("sample plain", 10'h080, 32'h00ABCDEF);
      chk("flag cleared", flag_o, 1'b0);
      apb(1'b1, 10'h014, 8'h45);
      chk("prefix enable", prefix_o, 1'b1);
      smp(24'h123456);
      rdc("status set", 10'h004, 32'h04);
      rdc("sample prefixed", 10'h080, 32'h04123456);
      apb(1'b1, 10'h010, 8'hF0);
      chk("pins driven", {oe, dout}, 8'hF5);
      rdc("data out", 10'h014, 32'h45);
      apb(1'b1, 10'h010, 8'hFF);
      chk("pins input", oe, 4'h0);
      repeat (3) @(posedge clk_i);
      rdc("data in", 10'h014, 32'h4A);
      apb(1'b1, 10'h010, 8'h0F);
      chk("pins loose", oe, 4'h0);
      rdc("data stored", 10'h014, 32'h45);
      apb(1'b0, 10'h018, 32'h0);
      chk("unmapped error", err, 1'b1);
      chk("unmapped data", q, 32'h0);
      apb(1'b1, 10'h009, 32'hFF);
      chk("misaligned", err, 1'b1);
      rdc("rate kept", 10'h008, 32'h27);
      // Continuous mode at 20 SPS, where the zero delay code is allowed.
      apb(1'b1, 10'h00C, 8'h00);
      ctl(1'b1, 1'b0);
      chk("zero delay run", conv_run_o, 1'b1);
      smp(24'h000001);
      chk("continuous run", {conv_run_o, shot_o}, 2'b10);
      ctl(1'b0, 1'b1);
      chk("stopped", conv_run_o, 1'b0);
      stop_test;
   end
endmodule // tb
